//--- verilog/tso_pkg.sv
// shared constants and carrier types of the transmit segmentation offload
package tso_pkg;

   // ****************************************************************
   // descriptor decoding
   // ****************************************************************
   localparam logic [1:0]  IPH_V6        = 2'h1;
   localparam logic [1:0]  IPH_V4_NOCS   = 2'h2;
   localparam logic [1:0]  IPH_V4_CS     = 2'h3;
   localparam logic [13:0] MIN_MSS       = 14'h0058;
   localparam logic [15:0] IPV6_BASE_HDR = 16'h0028;
   localparam logic [15:0] ID_STEP       = 16'h0001;
   // fin is bit 0, psh is bit 3 of the tcp flag byte
   localparam logic [7:0]  NONLAST_FLAGS = 8'hF6;

   typedef enum logic [1:0] {
      L4_UNKNOWN = 2'h0,
      L4_TCP     = 2'h1,
      L4_SCTP    = 2'h2,
      L4_UDP     = 2'h3
   } l4_type_e;

   typedef enum logic [4:0] {
      S_IDLE   = 5'h01,
      S_CHECK  = 5'h02,
      S_FIELDS = 5'h04,
      S_CSUM   = 5'h08,
      S_EMIT   = 5'h10
   } state_e;

   // ****************************************************************
   // context plus header template, as fetched from the ring
   // ****************************************************************
   typedef struct packed {
      logic        tso;
      logic        snap;
      logic        tunneled;
      logic [1:0]  ipHeaderTypeHint;
      l4_type_e    l4TypeHint;
      logic [6:0]  ipHeaderLength;       // dwords
      logic [6:0]  outerIpHeaderLength;  // dwords
      logic [7:0]  l4HeaderLength;       // bytes
      logic [17:0] datagramTotalLength;
      logic [13:0] mss;
      logic [15:0] ipIdInner;
      logic [15:0] ipIdOuter;
      logic [31:0] seqStart;
      logic [7:0]  tcpFlags;
      logic [15:0] pseudoSum;
      logic [15:0] ipv4SumInner;         // static header words only
      logic [15:0] ipv4SumOuter;
   } ctx_s;

   typedef struct packed {
      logic        first;
      logic        last;
      logic        ipCsumEn;
      logic        l4CsumEn;
      logic [13:0] payloadLen;
      logic [15:0] ipLenField;
      logic [15:0] outerLenField;
      logic [15:0] ipIdInner;
      logic [15:0] ipIdOuter;
      logic [31:0] seq;
      logic [7:0]  flags;
      logic [15:0] l4Seed;
      logic [15:0] ipCsumInner;
      logic [15:0] ipCsumOuter;
   } seg_s;

endpackage

//--- verilog/ones_add.sv
// 16-bit ones-complement adder with end-around carry
`timescale 1ns/1ps
`default_nettype none
module ones_add (
   input  wire logic [15:0] a,
   input  wire logic [15:0] b,
   output logic      [15:0] sum
);
   logic [16:0] raw;
   assign raw = {1'b0, a} + {1'b0, b};
   assign sum = raw[15:0] + {15'h0000, raw[16]};
endmodule // ones_add
`default_nettype wire

//--- verilog/tso_engine.sv
// transmit segmentation offload engine: per-segment header field rewrite
`timescale 1ns/1ps
`default_nettype none
// Contract
// - header hint 10b/11b is IPv4, 01b IPv6
// - l4 hint 11 UDP, 01 TCP, 10 SCTP, 00 none
// - IPv4 header checksum only for hint 11b
// - l4 checksum needs known type and lengths
// - datagram from one byte to 256KB minus one
// - only TCP over IP, no SNAP framing
// - context descriptor with flag precedes data
// - parameters come from the context descriptor
// - IPv4 length is payload plus both headers
// - inner and outer ids step by one
// - header checksum after all other fields
// - IPv6 length uses extensions, header minus forty
// - sequence advances by segment size
// - single segment handled as last segment
// - l4 sum seeded with pseudo plus length
// - bad segment size stops queue, flags event
// - segment size ignored without the flag
// - tail inside an operation halts queue
module tso_engine #(
   parameter logic [13:0] MaxMss = 14'h25C4
) (
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   input  wire tso_pkg::ctx_s ctx,
   input  wire logic          ctxValid,
   output logic               ctxReady,
   input  wire logic          tailInside,
   input  wire logic          queueRestart,
   output tso_pkg::seg_s      seg,
   output logic               segValid,
   input  wire logic          segReady,
   output logic               queueStopped,
   output logic               maliciousDriverEvent
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      tso_pkg::state_e state;
      tso_pkg::ctx_s   ctx;
      logic [17:0]     remain;
      logic [15:0]     idIn;
      logic [15:0]     idOut;
      logic [31:0]     seq;
      logic            stopped;
      logic            evt;
      tso_pkg::seg_s   seg;
      logic            segValid;
   } st_s;

   st_s st_q;
   st_s st_d;

   // ****************************************************************
   // decode
   // ****************************************************************
   logic        isV4;
   logic        isV6;
   logic        l4Known;
   logic        bad;
   logic        lastSeg;
   logic [13:0] payNext;
   logic [15:0] ipBytes;
   logic [15:0] outerBytes;
   logic [15:0] innerTotal;
   logic [15:0] tcpLen;
   logic [15:0] seedSum;
   logic [15:0] inPart;
   logic [15:0] inSum;
   logic [15:0] outPart;
   logic [15:0] outSum;

   assign isV4    = st_q.ctx.ipHeaderTypeHint[1];
   assign isV6    = st_q.ctx.ipHeaderTypeHint == tso_pkg::IPH_V6;
   assign l4Known = st_q.ctx.l4TypeHint != tso_pkg::L4_UNKNOWN;
   assign ipBytes    = {7'h00, st_q.ctx.ipHeaderLength, 2'h0};
   assign outerBytes = {7'h00, st_q.ctx.outerIpHeaderLength, 2'h0};

   // segment size is only judged when segmentation is asked for
   assign bad = st_q.ctx.tso && (st_q.ctx.mss < tso_pkg::MIN_MSS
                || st_q.ctx.mss > MaxMss
                || st_q.ctx.datagramTotalLength == 18'h00000
                || st_q.ctx.l4TypeHint != tso_pkg::L4_TCP
                || st_q.ctx.snap);

   assign lastSeg = st_q.remain <= {4'h0, st_q.ctx.mss};
   assign payNext = lastSeg ? st_q.remain[13:0] : st_q.ctx.mss;
   assign innerTotal = 16'(payNext) + {8'h00, st_q.ctx.l4HeaderLength} + ipBytes;
   assign tcpLen     = 16'(st_q.seg.payloadLen) + {8'h00, st_q.ctx.l4HeaderLength};

   // ****************************************************************
   // checksums over the already rewritten header fields
   // ****************************************************************
   ones_add u_seed (
      .a   (st_q.ctx.pseudoSum),
      .b   (tcpLen),
      .sum (seedSum)
   );
   ones_add u_in_len (
      .a   (st_q.ctx.ipv4SumInner),
      .b   (st_q.seg.ipLenField),
      .sum (inPart)
   );
   ones_add u_in_id (
      .a   (inPart),
      .b   (st_q.seg.ipIdInner),
      .sum (inSum)
   );
   ones_add u_out_len (
      .a   (st_q.ctx.ipv4SumOuter),
      .b   (st_q.seg.outerLenField),
      .sum (outPart)
   );
   ones_add u_out_id (
      .a   (outPart),
      .b   (st_q.seg.ipIdOuter),
      .sum (outSum)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_d     = st_q;
      st_d.evt = 1'b0;
      case (st_q.state)
         tso_pkg::S_IDLE: begin
            if (ctxValid && !st_q.stopped) begin
               st_d.ctx   = ctx;
               st_d.state = tso_pkg::S_CHECK;
            end
         end
         tso_pkg::S_CHECK: begin
            if (bad) begin
               st_d.stopped = 1'b1;
               st_d.evt     = 1'b1;
               st_d.state   = tso_pkg::S_IDLE;
            end else begin
               st_d.remain    = st_q.ctx.datagramTotalLength;
               st_d.idIn      = st_q.ctx.ipIdInner;
               st_d.idOut     = st_q.ctx.ipIdOuter;
               st_d.seq       = st_q.ctx.seqStart;
               st_d.seg.first = 1'b1;
               st_d.state     = tso_pkg::S_FIELDS;
            end
         end
         tso_pkg::S_FIELDS: begin
            st_d.seg.ipCsumEn = st_q.ctx.ipHeaderTypeHint == tso_pkg::IPH_V4_CS;
            st_d.seg.l4CsumEn = l4Known && st_q.ctx.l4HeaderLength != 8'h00
                                && st_q.ctx.ipHeaderLength != 7'h00;
            if (st_q.ctx.tso) begin
               st_d.seg.last       = lastSeg;
               st_d.seg.payloadLen = payNext;
               if (isV6)
                  st_d.seg.ipLenField = innerTotal - tso_pkg::IPV6_BASE_HDR;
               else
                  st_d.seg.ipLenField = innerTotal;
               st_d.seg.outerLenField = st_q.ctx.tunneled ? innerTotal + outerBytes : 16'h0000;
               st_d.seg.ipIdInner     = st_q.idIn;
               st_d.seg.ipIdOuter     = st_q.idOut;
               st_d.seg.seq           = st_q.seq;
               // a lone segment keeps every template flag, as a last one would
               st_d.seg.flags = lastSeg ? st_q.ctx.tcpFlags
                                        : st_q.ctx.tcpFlags & tso_pkg::NONLAST_FLAGS;
               st_d.state     = tso_pkg::S_CSUM;
            end else begin
               // single send: lengths stay as the driver built them
               st_d.seg.last          = 1'b1;
               st_d.seg.payloadLen    = 14'h0000;
               st_d.seg.ipLenField    = 16'h0000;
               st_d.seg.outerLenField = 16'h0000;
               st_d.seg.ipIdInner     = st_q.ctx.ipIdInner;
               st_d.seg.ipIdOuter     = st_q.ctx.ipIdOuter;
               st_d.seg.seq           = st_q.ctx.seqStart;
               st_d.seg.flags         = st_q.ctx.tcpFlags;
               st_d.seg.l4Seed        = st_q.ctx.pseudoSum;
               st_d.seg.ipCsumInner   = 16'h0000;
               st_d.seg.ipCsumOuter   = 16'h0000;
               st_d.seg.first         = 1'b1;
               st_d.segValid          = 1'b1;
               st_d.state             = tso_pkg::S_EMIT;
            end
         end
         tso_pkg::S_CSUM: begin
            // length and id are already registered, so the sum sees final values
            st_d.seg.l4Seed      = seedSum;
            st_d.seg.ipCsumInner = (isV4 && st_q.seg.ipCsumEn) ? ~inSum : 16'h0000;
            st_d.seg.ipCsumOuter = (st_q.ctx.tunneled && st_q.seg.ipCsumEn) ? ~outSum : 16'h0000;
            st_d.segValid        = 1'b1;
            st_d.state           = tso_pkg::S_EMIT;
         end
         tso_pkg::S_EMIT: begin
            if (segReady) begin
               st_d.segValid = 1'b0;
               if (st_q.seg.last) begin
                  st_d.state = tso_pkg::S_IDLE;
               end else begin
                  st_d.remain    = st_q.remain - {4'h0, st_q.seg.payloadLen};
                  st_d.idIn      = st_q.idIn + tso_pkg::ID_STEP;
                  st_d.idOut     = st_q.idOut + tso_pkg::ID_STEP;
                  st_d.seq       = st_q.seq + {18'h00000, st_q.ctx.mss};
                  st_d.seg.first = 1'b0;
                  st_d.state     = tso_pkg::S_FIELDS;
               end
            end
         end
         default: begin
            st_d.state    = tso_pkg::S_IDLE;
            st_d.segValid = 1'b0;
         end
      endcase
      // a doorbell inside an operation abandons it and halts the queue
      if (tailInside) begin
         st_d.stopped  = 1'b1;
         st_d.evt      = 1'b1;
         st_d.segValid = 1'b0;
         st_d.state    = tso_pkg::S_IDLE;
      end else if (queueRestart && st_q.stopped) begin
         st_d.stopped = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q       <= '0;
         st_q.state <= tso_pkg::S_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign ctxReady             = st_q.state == tso_pkg::S_IDLE && !st_q.stopped;
   assign seg                  = st_q.seg;
   assign segValid             = st_q.segValid;
   assign queueStopped         = st_q.stopped;
   assign maliciousDriverEvent = st_q.evt;

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [15:0] prevIdQ;
   logic [31:0] prevSeqQ;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prevIdQ  <= 16'h0000;
         prevSeqQ <= 32'h00000000;
      end else if (segValid && segReady) begin
         prevIdQ  <= seg.ipIdInner;
         prevSeqQ <= seg.seq;
      end
   end

   a_bad_mss_stops: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q.state == tso_pkg::S_CHECK && bad && !tailInside |=> queueStopped && maliciousDriverEvent)
      else $error("bad segment size did not stop the queue");
   a_stop_blocks_ctx: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tailInside |=> queueStopped && !ctxReady && !segValid)
      else $error("queue accepted work after a bad tail");
   a_ipv4_len_field: assert property (@(posedge sys_clk) disable iff (!reset_n)
      segValid && st_q.ctx.tso && isV4 |-> seg.ipLenField ==
         16'(seg.payloadLen) + {8'h00, st_q.ctx.l4HeaderLength} + ipBytes)
      else $error("ipv4 total length wrong");
   a_ipv6_len_field: assert property (@(posedge sys_clk) disable iff (!reset_n)
      segValid && st_q.ctx.tso && isV6 |-> seg.ipLenField + 16'h0028 ==
         16'(seg.payloadLen) + {8'h00, st_q.ctx.l4HeaderLength} + ipBytes)
      else $error("ipv6 payload length wrong");
   a_id_step_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(segValid) && st_q.ctx.tso && !seg.first |-> seg.ipIdInner == prevIdQ + 16'h0001)
      else $error("identification did not step by one");
   a_seq_step_mss: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(segValid) && st_q.ctx.tso && !seg.first |-> seg.seq == prevSeqQ + {18'h00000, st_q.ctx.mss})
      else $error("sequence did not advance by segment size");
   a_nonlast_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
      segValid && !seg.last |-> !seg.flags[0] && !seg.flags[3])
      else $error("fin or psh set on a middle segment");
   a_csum_after_fields: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(segValid) && st_q.ctx.tso |-> $past(st_q.state, 1) == tso_pkg::S_CSUM
         && $past(st_q.state, 2) == tso_pkg::S_FIELDS)
      else $error("checksum not taken after field update");
   a_ipv4_cs_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
      segValid |-> seg.ipCsumEn == (st_q.ctx.ipHeaderTypeHint == tso_pkg::IPH_V4_CS)
         && (seg.ipCsumEn || (seg.ipCsumInner == 16'h0000 && seg.ipCsumOuter == 16'h0000)))
      else $error("ipv4 checksum enable mis-decoded");
   a_seg_held: assert property (@(posedge sys_clk) disable iff (!reset_n)
      segValid && !segReady && !tailInside |=> segValid && $stable(seg))
      else $error("segment dropped before it was taken");

endmodule // tso_engine
`default_nettype wire

//--- verification/tso_host_model.sv
// host driver model: posts contexts and takes rewritten segments
`timescale 1ns/1ps
`default_nettype none
module tso_host_model (
   input  wire logic          sys_clk,
   input  wire logic          slow,
   output var tso_pkg::ctx_s  ctx,
   output var logic           ctxValid,
   input  wire logic          ctxReady,
   input  wire tso_pkg::seg_s seg,
   input  wire logic          segValid,
   output var logic           segReady
);
   tso_pkg::seg_s segQ[$];

   initial begin
      ctx = '0;
      ctxValid = 1'b0;
      segReady = 1'b0;
   end

   // a slow host takes a segment only every other cycle; the queue
   // records what the next rising edge hands over
   always @(negedge sys_clk) begin
      segReady = slow ? ~segReady : 1'b1;
      #1 if (segValid && segReady) segQ.push_back(seg);
   end

   // one context ahead of its data, held until it is taken or 50 cycles pass
   task automatic post(input tso_pkg::ctx_s c, output logic ok);
      int w;
      ok = 1'b0;
      w = 0;
      @(negedge sys_clk);
      ctx = c;
      ctxValid = 1'b1;
      while (!ok && w < 50) begin
         #1 ok = ctxReady;
         @(posedge sys_clk);
         w++;
      end
      @(negedge sys_clk);
      ctxValid = 1'b0;
      // released bus shows no stale value
      ctx = ~c;
   endtask
endmodule // tso_host_model
`default_nettype wire

//--- verification/tb_tso_engine.sv
// self-checking bench of the segmentation offload engine
`timescale 1ns/1ps
`default_nettype none
module tb_tso_engine;
   // ********************************
   // clock, reset and the two parties
   // ********************************
   // a small ceiling keeps the oversize case cheap to reach
   localparam logic [13:0] MaxMss = 14'h0100;
   logic          sys_clk = 1'b0;
   logic          reset_n = 1'b0;
   logic          tailInside = 1'b0;
   logic          queueRestart = 1'b0;
   logic          slow = 1'b0;
   logic          ctxValid, ctxReady, segValid, segReady, queueStopped, maliciousDriverEvent;
   tso_pkg::ctx_s ctx;
   tso_pkg::seg_s seg;
   int            mismatches = 0;
   int            samplesChecked = 0;

   always #25 sys_clk = ~sys_clk;

   tso_engine #(.MaxMss(MaxMss)) tso_engine_i (.sys_clk(sys_clk), .reset_n(reset_n), .ctx(ctx),
      .ctxValid(ctxValid), .ctxReady(ctxReady), .tailInside(tailInside), .queueRestart(queueRestart),
      .seg(seg), .segValid(segValid), .segReady(segReady), .queueStopped(queueStopped),
      .maliciousDriverEvent(maliciousDriverEvent));
   tso_host_model tso_host_model_i (.sys_clk(sys_clk), .slow(slow), .ctx(ctx), .ctxValid(ctxValid),
      .ctxReady(ctxReady), .seg(seg), .segValid(segValid), .segReady(segReady));

   // ********************************
   // helpers
   // ********************************
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [255:0] got, input logic [255:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0d ns: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic guard(input logic good);
      if (good !== 1'b1) begin
         mismatches++;
         stop_test();
      end
   endtask

   function automatic logic [15:0] oadd(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = a + b;
      return s[15:0] + 16'(s[16]);
   endfunction

   // pseudo sum leaves out the tcp length; inner id and sequence sit near wrap
   // headers stay far below the header limit and each segment sits in one buffer
   function automatic tso_pkg::ctx_s mk(input logic t, input logic [1:0] h, input logic [1:0] l4,
                                        input logic [6:0] il, input logic [17:0] n, input logic [13:0] m);
      return '{tso: t, ipHeaderTypeHint: h, l4TypeHint: tso_pkg::l4_type_e'(l4), ipHeaderLength: il,
               datagramTotalLength: n, mss: m, l4HeaderLength: 8'h14, ipIdInner: 16'hFFFE,
               ipIdOuter: 16'h1234, seqStart: 32'hFFFFFF00, tcpFlags: 8'h19, pseudoSum: 16'hFFF0,
               ipv4SumInner: 16'h8001, ipv4SumOuter: 16'hC0DE, default: '0};
   endfunction

   task automatic run(input tso_pkg::ctx_s c, input int n);
      logic          ok;
      int            w;
      tso_pkg::seg_s s, e;
      logic [15:0]   x;
      tso_host_model_i.segQ.delete();
      tso_host_model_i.post(c, ok);
      guard(ok);
      w = 0;
      // completion is judged by the count of segments taken, n of them
      while (tso_host_model_i.segQ.size() < n && w < 20 * n + 40) begin
         @(posedge sys_clk);
         w++;
      end
      guard(w < 20 * n + 40);
      for (int k = 0; k < n; k++) begin
         s = tso_host_model_i.segQ[k];
         e = '0;
         e.first = (k == 0);
         e.last = (k == n - 1);
         e.ipCsumEn = (c.ipHeaderTypeHint == tso_pkg::IPH_V4_CS);
         e.l4CsumEn = (c.l4TypeHint != tso_pkg::L4_UNKNOWN) && c.l4HeaderLength != 8'h00
                      && c.ipHeaderLength != 7'h00;
         e.flags = c.tcpFlags;
         e.l4Seed = c.pseudoSum;
         if (c.tso) begin
            e.payloadLen = e.last ? 14'(c.datagramTotalLength - k * c.mss) : c.mss;
            x = 16'(e.payloadLen) + 16'(c.l4HeaderLength) + 16'({c.ipHeaderLength, 2'b00});
            e.ipLenField = (c.ipHeaderTypeHint == tso_pkg::IPH_V6) ? x - tso_pkg::IPV6_BASE_HDR : x;
            e.outerLenField = c.tunneled ? x + 16'({c.outerIpHeaderLength, 2'b00}) : 16'h0000;
            e.ipIdInner = c.ipIdInner + 16'(k);
            e.ipIdOuter = c.ipIdOuter + 16'(k);
            e.seq = c.seqStart + 32'(k) * 32'(c.mss);
            if (!e.last) e.flags = c.tcpFlags & tso_pkg::NONLAST_FLAGS;
            e.l4Seed = oadd(c.pseudoSum, 16'(e.payloadLen) + 16'(c.l4HeaderLength));
            if (e.ipCsumEn) e.ipCsumInner = ~oadd(oadd(c.ipv4SumInner, e.ipLenField), e.ipIdInner);
            if (e.ipCsumEn && c.tunneled) e.ipCsumOuter = ~oadd(oadd(c.ipv4SumOuter, e.outerLenField), e.ipIdOuter);
         end else begin
            // a single send passes the template ids and sequence through untouched
            e.ipIdInner = c.ipIdInner;
            e.ipIdOuter = c.ipIdOuter;
            e.seq = c.seqStart;
         end
         check(s, e);
      end
   endtask

   task automatic restart();
      @(negedge sys_clk);
      queueRestart = 1'b1;
      @(negedge sys_clk);
      queueRestart = 1'b0;
      check(ctxReady, 1'b1);
   endtask

   task automatic bad(input tso_pkg::ctx_s c);
      logic ok;
      int   p;
      p = 0;
      tso_host_model_i.segQ.delete();
      tso_host_model_i.post(c, ok);
      repeat (6) begin
         @(posedge sys_clk);
         #1 p += int'(maliciousDriverEvent === 1'b1);
      end
      check(p, 1);
      check({queueStopped, ctxReady, segValid}, 3'b100);
      check(tso_host_model_i.segQ.size(), 0);
      restart();
   endtask

   initial begin
      tso_pkg::ctx_s c;
      logic          ok;
      int            w;
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      // single sends over header hints 01b to 11b with every l4 hint; the stray segment size is ignored
      for (int h = 1; h < 4; h++) begin
         for (int l = 0; l < 4; l++) begin
            run(mk(1'b0, 2'(h), 2'(l), 7'h05, 18'h00000, 14'h0010), 1);
         end
      end
      c = mk(1'b1, tso_pkg::IPH_V4_CS, tso_pkg::L4_TCP, 7'h05, 18'h000C8, 14'h0058);
      c.tunneled = 1'b1;
      c.outerIpHeaderLength = 7'h05;
      run(c, 3);
      slow = 1'b1;
      run(mk(1'b1, tso_pkg::IPH_V6, tso_pkg::L4_TCP, 7'h0C, 18'h00001, 14'h0100), 1);
      // tunnelled with hint 10b: the outer checksum must stay untouched too
      c = mk(1'b1, tso_pkg::IPH_V4_NOCS, tso_pkg::L4_TCP, 7'h0F, 18'h3FFFF, MaxMss);
      c.tunneled = 1'b1;
      c.outerIpHeaderLength = 7'h05;
      run(c, 1024);
      c = mk(1'b1, tso_pkg::IPH_V4_CS, tso_pkg::L4_TCP, 7'h05, 18'h00100, 14'h0057);
      bad(c);
      c.mss = MaxMss + 14'h0001;
      bad(c);
      c.mss = 14'h0058;
      c.snap = 1'b1;
      bad(c);
      c.snap = 1'b0;
      c.l4TypeHint = tso_pkg::L4_UDP;
      bad(c);
      // tail written mid-operation; the restart beside it must lose
      c.l4TypeHint = tso_pkg::L4_TCP;
      tso_host_model_i.post(c, ok);
      guard(ok);
      w = 0;
      while (segValid !== 1'b1 && w < 20) begin
         @(posedge sys_clk);
         #1 w++;
      end
      guard(w < 20);
      @(negedge sys_clk);
      tailInside = 1'b1;
      queueRestart = 1'b1;
      @(negedge sys_clk);
      tailInside = 1'b0;
      queueRestart = 1'b0;
      check({queueStopped, segValid, ctxReady, maliciousDriverEvent}, 4'b1001);
      restart();
      c.datagramTotalLength = 18'h000B0;
      run(c, 2);
      stop_test();
   end
endmodule // tb_tso_engine
`default_nettype wire
